// file: common/pss_cfg.svh
// Timing figures and reset values for the power supervisor sequencer.
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// Clock rate in kHz (10 MHz, 100 ns period).
`define PSS_CLK_KHZ        10000
// Debounce intervals in milliseconds.
`define PSS_DEB_EN_MS      30
`define PSS_DEB_CHG_MS     120
`define PSS_DEB_GPI_MS     30
// Length of one sequencer slot in microseconds.
`define PSS_SLOT_US        1280
// Number of sequencing events per power-up or power-down.
`define PSS_NUM_EVENTS     4
// Number of supply resources (three buck-boost rails and one linear regulator).
`define PSS_NUM_RAILS      4
// Index of the linear regulator in the rail enable vector.
`define PSS_LDO_IDX        3
// Reset values.
`define PSS_RST_RAILS      4'h0
`define PSS_RST_BIAS       1'b0
// Reset value of the enable button filter: released, so the pin idles high.
`define PSS_RST_EN_FILT    1'b1

`endif

// file: common/pss_pkg.sv
// Types shared by the power supervisor sequencer and its bench.
package pss_pkg;

  // On/off controller states, one-hot.
  typedef enum logic [5:0] {
    PSS_ST_OFF       = 6'h01,
    PSS_ST_BIAS_UP   = 6'h02,
    PSS_ST_SEQ_UP    = 6'h04,
    PSS_ST_ON        = 6'h08,
    PSS_ST_SEQ_DOWN  = 6'h10,
    PSS_ST_BIAS_DOWN = 6'h20
  } pss_state_e;

  // How one supply resource is enabled.
  typedef enum logic [1:0] {
    PSS_MODE_OFF   = 2'h0,
    PSS_MODE_SW_ON = 2'h1,
    PSS_MODE_SEQ   = 2'h2
  } pss_mode_e;

  // Per-resource configuration: mode and the sequencer slots for up and down.
  typedef struct packed {
    pss_mode_e  mode;
    logic [1:0] up_slot;
    logic [1:0] down_slot;
  } pss_rail_cfg_s;

  // Temperature alarm status, live.
  typedef struct packed {
    logic alarm_high;
    logic alarm_low;
  } pss_temp_flags_s;

endpackage : pss_pkg

// file: verilog/pss_top.sv
// Power supervisor: debounce filters, thermal alarms, lockout and flexible sequencer.
`timescale 1ns/1ps
`include "pss_cfg.svh"


module pss_top #(
  parameter int DEB_EN_CYC  = `PSS_DEB_EN_MS * `PSS_CLK_KHZ,   // enable button debounce
  parameter int DEB_CHG_CYC = `PSS_DEB_CHG_MS * `PSS_CLK_KHZ,  // charge source debounce
  parameter int DEB_GPI_CYC = `PSS_DEB_GPI_MS * `PSS_CLK_KHZ,  // general input debounce
  parameter int SLOT_CYC    = (`PSS_SLOT_US * `PSS_CLK_KHZ) / 1000 // cycles per sequencer slot
) (
  input  wire logic                                  mclk_i,                  // 10 MHz clock
  input  wire logic                                  resetn_i,                // sync reset, low
  input  wire logic                                  enable_button_input_n_i, // pin, low = on
  input  wire logic                                  charge_source_input_i,   // source valid pin
  input  wire logic                                  general_input_pin_i,     // general pin
  input  wire logic                                  gpi_as_input_i,          // pin is an input
  input  wire logic                                  temp_above_low_i,        // above 80 C
  input  wire logic                                  temp_above_high_i,       // above 100 C
  input  wire logic                                  temp_above_lockout_i,    // above trip
  input  wire logic                                  temp_below_release_i,    // 15 C below trip
  input  wire logic                                  bias_ready_i,            // main bias is up
  input  wire logic                                  sw_on_req_i,             // software on
  input  wire pss_pkg::pss_rail_cfg_s [`PSS_NUM_RAILS-1:0] rail_cfg_i,        // per-rail setup
  input  wire pss_pkg::pss_temp_flags_s              temp_irq_mask_i,         // 1 masks alarm
  output logic [`PSS_NUM_RAILS-1:0]                  rail_en_o,               // rail enables
  output logic                                       main_bias_en_o,          // bias request
  output logic                                       enable_button_filt_n_o,  // filtered, low
  output logic                                       charge_source_filt_o,    // filtered
  output logic                                       general_input_filt_o,    // filtered
  output pss_pkg::pss_temp_flags_s                   temp_flags_o,            // live alarms
  output logic                                       temp_irq_o,              // change pulse
  output logic                                       overtemp_lockout_o,      // lockout held
  output pss_pkg::pss_state_e                        state_o                  // controller state
);

  localparam int DEB_W  = 21;
  localparam int SLOT_W = 16;
  localparam int NDEB   = 3;
  localparam logic [DEB_W-1:0] DEB_LEN [NDEB] = '{
    DEB_W'(DEB_EN_CYC), DEB_W'(DEB_CHG_CYC), DEB_W'(DEB_GPI_CYC)
  };
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYC - 1);
  localparam logic [1:0]        EV_LAST   = 2'(`PSS_NUM_EVENTS - 1);

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Every pin comes from analog or the outside world, so all of them
  // pass two flops; only the second stage is read below.

  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync_a_r;
  logic [NSYNC-1:0] sync_b_r;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sync_a_r <= 8'h01;
      sync_b_r <= 8'h01;
    end else begin
      sync_a_r <= {bias_ready_i, temp_below_release_i, temp_above_lockout_i,
                   temp_above_high_i, temp_above_low_i, general_input_pin_i,
                   charge_source_input_i, enable_button_input_n_i};
      sync_b_r <= sync_a_r;
    end
  end

  logic en_s;
  logic chg_s;
  logic gpi_s;
  logic al_lo_s;
  logic al_hi_s;
  logic overtemp_lockout_s;
  logic rel_s;
  logic bias_s;
  assign {bias_s, rel_s, overtemp_lockout_s, al_hi_s, al_lo_s, gpi_s, chg_s, en_s} = sync_b_r;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Debounce filters. A counter runs while the input differs from the filtered level and
  // restarts whenever the two agree, so any short excursion is thrown away.

  logic [DEB_W-1:0] deb_cnt_r [NDEB];
  logic [NDEB-1:0]  deb_filt_r;
  logic [NDEB-1:0]  deb_in;

  // A general pin used as an output is held at zero so no stale level leaks through.
  assign deb_in = {gpi_s & gpi_as_input_i, chg_s, en_s};

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      deb_filt_r <= {2'h0, `PSS_RST_EN_FILT};
      for (int i = 0; i < NDEB; i++) begin
        deb_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NDEB; i++) begin
        if (deb_in[i] == deb_filt_r[i]) begin
          deb_cnt_r[i] <= '0;
        end else if (deb_cnt_r[i] >= DEB_LEN[i] - 1'b1) begin
          deb_filt_r[i] <= deb_in[i];
          deb_cnt_r[i]  <= '0;
        end else begin
          deb_cnt_r[i] <= deb_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      enable_button_filt_n_o <= `PSS_RST_EN_FILT;
      charge_source_filt_o   <= 1'b0;
      general_input_filt_o   <= 1'b0;
    end else begin
      enable_button_filt_n_o <= deb_filt_r[0];
      charge_source_filt_o   <= deb_filt_r[1];
      general_input_filt_o   <= deb_filt_r[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Thermal alarms. Flags track the comparators; the interrupt is a one-cycle pulse on any
  // change of a flag that is not masked.

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      temp_flags_o <= '0;
      temp_irq_o   <= 1'b0;
    end else begin
      temp_flags_o.alarm_low  <= al_lo_s;
      temp_flags_o.alarm_high <= al_hi_s;
      // Comparing the synced level with the flag gives both edges from one xor.
      temp_irq_o <= ((al_lo_s ^ temp_flags_o.alarm_low) & ~temp_irq_mask_i.alarm_low) |
                    ((al_hi_s ^ temp_flags_o.alarm_high) & ~temp_irq_mask_i.alarm_high);
    end
  end

  // Lockout holds from the trip until the release comparator reports the hysteresis point.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      overtemp_lockout_o <= 1'b0;
    end else if (overtemp_lockout_s) begin
      overtemp_lockout_o <= 1'b1;
    end else if (rel_s) begin
      overtemp_lockout_o <= 1'b0;
    end
  end

  // The synced trip is used directly as well, so the rails drop in the same cycle as the
  // lockout flag rises rather than one cycle after it.
  logic lockout;
  assign lockout = overtemp_lockout_s | overtemp_lockout_o;

  //////////////////////////////////////////////////////////////////////////////////////////
  // On/off controller and master sequencing timer.

  // True in the states in which the rails may carry power.
  function automatic logic rails_live(input pss_pkg::pss_state_e s);
    return (s == pss_pkg::PSS_ST_SEQ_UP) || (s == pss_pkg::PSS_ST_ON) ||
           (s == pss_pkg::PSS_ST_SEQ_DOWN);
  endfunction : rails_live

  logic                 on_req;
  logic [SLOT_W-1:0]    slot_cnt_r;
  logic [1:0]           ev_idx_r;
  logic                 seq_run;
  logic                 seq_evt;
  logic                 seq_done;
  pss_pkg::pss_state_e  state_r;
  pss_pkg::pss_state_e  state_nxt;

  // Hardware sources are the filtered button and a valid charge source. The filter state
  // is read, not the output flop, to save a cycle of latency on every button or charge-source request.
  assign on_req   = sw_on_req_i | ~deb_filt_r[0] | deb_filt_r[1];
  assign seq_run  = (state_r == pss_pkg::PSS_ST_SEQ_UP) ||
                    (state_r == pss_pkg::PSS_ST_SEQ_DOWN);
  assign seq_evt  = seq_run && (slot_cnt_r == SLOT_LAST);
  assign seq_done = seq_evt && (ev_idx_r == EV_LAST);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pss_pkg::PSS_ST_OFF: begin
        if (on_req && !lockout) begin
          state_nxt = pss_pkg::PSS_ST_BIAS_UP;
        end
      end
      pss_pkg::PSS_ST_BIAS_UP: begin
        if (lockout) begin
          state_nxt = pss_pkg::PSS_ST_BIAS_DOWN;
        end else if (bias_s) begin
          state_nxt = pss_pkg::PSS_ST_SEQ_UP;
        end
      end
      pss_pkg::PSS_ST_SEQ_UP: begin
        if (lockout) begin
          state_nxt = pss_pkg::PSS_ST_BIAS_DOWN;
        end else if (seq_done) begin
          state_nxt = pss_pkg::PSS_ST_ON;
        end
      end
      pss_pkg::PSS_ST_ON: begin
        if (lockout) begin
          state_nxt = pss_pkg::PSS_ST_BIAS_DOWN;
        end else if (!on_req) begin
          state_nxt = pss_pkg::PSS_ST_SEQ_DOWN;
        end
      end
      pss_pkg::PSS_ST_SEQ_DOWN: begin
        if (lockout || seq_done) begin
          state_nxt = pss_pkg::PSS_ST_BIAS_DOWN;
        end
      end
      pss_pkg::PSS_ST_BIAS_DOWN: begin
        if (!bias_s) begin
          state_nxt = pss_pkg::PSS_ST_OFF;
        end
      end
      default: state_nxt = pss_pkg::PSS_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r        <= pss_pkg::PSS_ST_OFF;
      state_o        <= pss_pkg::PSS_ST_OFF;
      main_bias_en_o <= `PSS_RST_BIAS;
    end else begin
      state_r        <= state_nxt;
      state_o        <= state_nxt;
      // Decoded from the next state so the bias request leaves with the state change.
      main_bias_en_o <= (state_nxt == pss_pkg::PSS_ST_BIAS_UP) || rails_live(state_nxt);
    end
  end

  // The single master timer; slot count and event index restart on every sequence entry.
  // A lockout in mid-sequence therefore never leaves a stale event index for the next run.
  // The first event falls one full slot after entry, so even slot 0 gets its delay.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || !seq_run || (state_nxt != state_r)) begin
      slot_cnt_r <= '0;
      ev_idx_r   <= '0;
    end else if (seq_evt) begin
      slot_cnt_r <= '0;
      ev_idx_r   <= ev_idx_r + 1'b1;
    end else begin
      slot_cnt_r <= slot_cnt_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Resource enables. Sequenced rails switch on the event that matches their slot; rails
  // sharing a slot form a group. Lockout clears everything in one cycle, ignoring slots.

  logic up_evt;
  logic dn_evt;
  logic powered;
  assign up_evt  = seq_evt && (state_r == pss_pkg::PSS_ST_SEQ_UP);
  assign dn_evt  = seq_evt && (state_r == pss_pkg::PSS_ST_SEQ_DOWN);
  assign powered = rails_live(state_r);

  // A rail in sequenced mode keeps its level between events; a slot that no event index
  // reaches simply never switches that rail. Software-mode rails follow the powered states
  // one cycle late, which keeps them off until the bias is up.
  // Illegal mode codes fall to the default branch and hold the rail off.

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rail_en_o <= `PSS_RST_RAILS;
    end else if (lockout) begin
      rail_en_o <= '0;
    end else begin
      for (int i = 0; i < `PSS_NUM_RAILS; i++) begin
        unique case (rail_cfg_i[i].mode)
          pss_pkg::PSS_MODE_SW_ON: rail_en_o[i] <= powered;
          pss_pkg::PSS_MODE_SEQ: begin
            if (!powered) begin
              rail_en_o[i] <= 1'b0;
            end else if (up_evt && (rail_cfg_i[i].up_slot == ev_idx_r)) begin
              rail_en_o[i] <= 1'b1;
            end else if (dn_evt && (rail_cfg_i[i].down_slot == ev_idx_r)) begin
              rail_en_o[i] <= 1'b0;
            end
          end
          default: rail_en_o[i] <= 1'b0;
        endcase
      end
    end
  end

endmodule : pss_top

// file: verif/pss_monitor.sv
// Port checker for the power supervisor sequencer, bound to its top module.
`timescale 1ns/1ps
`include "pss_cfg.svh"
module pss_monitor #(
  parameter int DEB_CHG_CYC = 8,  // charge source debounce
  parameter int SLOT_CYC    = 10  // cycles per slot
) (
  input wire logic                            mclk_i,                // clock
  input wire logic                            resetn_i,              // reset, low
  input wire logic                            charge_source_input_i, // raw pin
  input wire logic                            temp_above_low_i,      // comparator
  input wire logic                            temp_above_high_i,     // comparator
  input wire logic                            temp_above_lockout_i,  // trip
  input wire logic                            temp_below_release_i,  // release
  input wire pss_pkg::pss_temp_flags_s        temp_irq_mask_i,       // masks
  input wire logic [`PSS_NUM_RAILS-1:0]       rail_en_o,             // rails
  input wire logic                            main_bias_en_o,        // bias
  input wire logic                            charge_source_filt_o,  // filtered
  input wire pss_pkg::pss_temp_flags_s        temp_flags_o,          // flags
  input wire logic                            temp_irq_o,            // pulse
  input wire logic                            overtemp_lockout_o,    // lockout
  input wire pss_pkg::pss_state_e             state_o                // state
);
  int   chg_cnt;
  int   up_cnt;
  logic chg_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Counts how long the raw pin has been steady; saturates so it cannot wrap.
  always_ff @(posedge mclk_i) begin
    chg_q <= charge_source_input_i;
    if (!resetn_i || charge_source_input_i != chg_q) chg_cnt <= 0;
    else if (chg_cnt < 100000) chg_cnt <= chg_cnt + 1;
  end
  always_ff @(posedge mclk_i) begin
    if (state_o != pss_pkg::PSS_ST_SEQ_UP) up_cnt <= 0;
    else up_cnt <= up_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_state_one_hot:
    assert property ($onehot(state_o)) else $error("state not one-hot");
  a_off_quiet:
    assert property (state_o == pss_pkg::PSS_ST_OFF |-> !main_bias_en_o && rail_en_o == 4'h0)
      else $error("supply on while off");
  a_seq_length:
    assert property (state_o == pss_pkg::PSS_ST_SEQ_UP ##1 state_o == pss_pkg::PSS_ST_ON
      |-> up_cnt >= 4 * SLOT_CYC - 1 && up_cnt <= 4 * SLOT_CYC + 1)
      else $error("power-up sequence length wrong");
  a_lock_rails_off:
    assert property (overtemp_lockout_o |-> rail_en_o == 4'h0) else $error("rails on in lockout");
  a_lock_follow_trip:
    assert property (temp_above_lockout_i [*4] |-> overtemp_lockout_o) else $error("no lockout");
  a_lock_held:
    assert property ((!temp_below_release_i) [*3] ##0 overtemp_lockout_o |=> overtemp_lockout_o)
      else $error("lockout dropped early");
  a_deb_hold_chg:
    assert property ($changed(charge_source_filt_o) |-> chg_cnt >= DEB_CHG_CYC)
      else $error("filter changed too soon");
  a_flag_low_live:
    assert property (temp_above_low_i [*4] |-> temp_flags_o.alarm_low) else $error("low flag");
  a_flag_high_live:
    assert property ((!temp_above_high_i) [*4] |-> !temp_flags_o.alarm_high)
      else $error("high flag stuck");
  a_irq_on_change:
    assert property ($changed(temp_flags_o.alarm_low) && !temp_irq_mask_i.alarm_low |-> temp_irq_o)
      else $error("missing alarm pulse");
  a_irq_has_cause:
    assert property (temp_irq_o |-> $changed(temp_flags_o)) else $error("spurious alarm pulse");
  c_on: cover property (state_o == pss_pkg::PSS_ST_ON);
  c_lock: cover property ($rose(overtemp_lockout_o));
  c_irq: cover property (temp_irq_o);
endmodule : pss_monitor

bind pss_top pss_monitor #(.DEB_CHG_CYC(DEB_CHG_CYC), .SLOT_CYC(SLOT_CYC)) u_mon (
  .mclk_i, .resetn_i, .charge_source_input_i, .temp_above_low_i, .temp_above_high_i,
  .temp_above_lockout_i, .temp_below_release_i, .temp_irq_mask_i, .rail_en_o,
  .main_bias_en_o, .charge_source_filt_o, .temp_flags_o, .temp_irq_o, .overtemp_lockout_o,
  .state_o);

// file: verif/pss_bias_model.sv
// Behavioural main bias that reports done some cycles after each request change.
`timescale 1ns/1ps
module pss_bias_model #(
  parameter int DLY = 6  // settling cycles
) (
  input  wire logic mclk_i,      // clock
  input  wire logic bias_en_i,   // bias request
  output logic      bias_ready_o // bias settled up
);
  int cnt = 0;
  initial bias_ready_o = 1'b0;
  // A real bias takes time both ways, so done never follows the request at once.
  always @(posedge mclk_i) begin
    if (bias_ready_o == bias_en_i) cnt <= 0;
    else if (cnt < DLY) cnt <= cnt + 1;
    else bias_ready_o <= bias_en_i;
  end
endmodule : pss_bias_model

// file: verif/test_pss_top.sv
// Self-checking bench for the power supervisor sequencer.
`timescale 1ns/1ps
module test_pss_top;
  localparam int DEB  = 8;
  localparam int SLOT = 10;
  logic mclk_i = 1'b0, resetn_i = 1'b0, enable_button_input_n_i = 1'b1;
  logic charge_source_input_i = 1'b0, general_input_pin_i = 1'b0, gpi_as_input_i = 1'b1;
  logic temp_above_low_i = 1'b0, temp_above_high_i = 1'b0, temp_above_lockout_i = 1'b0;
  logic temp_below_release_i = 1'b1, sw_on_req_i = 1'b0, bias_ready_i;
  pss_pkg::pss_rail_cfg_s [3:0] rail_cfg_i;
  pss_pkg::pss_temp_flags_s     temp_irq_mask_i = 2'h2;
  logic [3:0]                   rail_en_o;
  logic main_bias_en_o, enable_button_filt_n_o, charge_source_filt_o, general_input_filt_o;
  logic temp_irq_o, overtemp_lockout_o;
  pss_pkg::pss_temp_flags_s     temp_flags_o;
  pss_pkg::pss_state_e          state_o;
  int errors = 0, checks_done = 0, cyc = 0;
  pss_top #(.DEB_EN_CYC(DEB), .DEB_CHG_CYC(DEB), .DEB_GPI_CYC(DEB), .SLOT_CYC(SLOT)) u_dut (
    .mclk_i, .resetn_i, .enable_button_input_n_i, .charge_source_input_i, .general_input_pin_i,
    .gpi_as_input_i, .temp_above_low_i, .temp_above_high_i, .temp_above_lockout_i,
    .temp_below_release_i, .bias_ready_i, .sw_on_req_i, .rail_cfg_i, .temp_irq_mask_i,
    .rail_en_o, .main_bias_en_o, .enable_button_filt_n_o, .charge_source_filt_o,
    .general_input_filt_o, .temp_flags_o, .temp_irq_o, .overtemp_lockout_o, .state_o);
  pss_bias_model u_bias (.mclk_i, .bias_en_i(main_bias_en_o), .bias_ready_o(bias_ready_i));
  always #50 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic hold(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : hold
  task automatic wait_st(input pss_pkg::pss_state_e s);
    int n;
    n = 0;
    while (state_o !== s && n < 300) begin
      hold(1);
      n++;
    end
    chk(8'(state_o), 8'(s), "state");
  endtask : wait_st
  // Walks the rail enables through their changes; a gap of 0 is not timed.
  task automatic follow(input logic [3:0] v[4], input int g[4]);
    logic [3:0] prev;
    int         t0, n;
    prev = rail_en_o;
    t0 = cyc;
    foreach (v[i]) begin
      n = 0;
      while (rail_en_o === prev && n < 100) begin
        hold(1);
        n++;
      end
      if (g[i] != 0) chk(8'(cyc - t0), 8'(g[i]), "event spacing");
      chk(8'(rail_en_o), 8'(v[i]), "rail order");
      prev = rail_en_o;
      t0 = cyc;
    end
  endtask : follow
  task automatic deb_gp(input logic lvl);
    general_input_pin_i = lvl;
    hold(DEB - 2);
    general_input_pin_i = ~lvl;
    hold(DEB + 6);
    chk({7'h0, general_input_filt_o}, {7'h0, ~lvl}, "glitch kept out");
    general_input_pin_i = lvl;
    hold(DEB - 1);
    chk({7'h0, general_input_filt_o}, {7'h0, ~lvl}, "early change");
    hold(7);
    chk({7'h0, general_input_filt_o}, {7'h0, lvl}, "filtered level");
  endtask : deb_gp
  task automatic irq_step(input logic lo, input logic hi, input int exp_n);
    int n;
    n = 0;
    temp_above_low_i = lo;
    temp_above_high_i = hi;
    repeat (8) begin
      hold(1);
      if (temp_irq_o === 1'b1) n++;
    end
    chk(8'(n), 8'(exp_n), "alarm pulses");
    chk(8'(temp_flags_o), {6'h0, hi, lo}, "alarm flags");
  endtask : irq_step
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("BAD %0t run hung", $time);
      finish_test();
    end
  end
  initial begin
    rail_cfg_i[0] = {pss_pkg::PSS_MODE_SEQ, 2'h0, 2'h3};
    rail_cfg_i[1] = {pss_pkg::PSS_MODE_SEQ, 2'h1, 2'h2};
    rail_cfg_i[2] = {pss_pkg::PSS_MODE_SEQ, 2'h3, 2'h0};
    rail_cfg_i[3] = {pss_pkg::PSS_MODE_SW_ON, 2'h0, 2'h0};
    hold(20);
    resetn_i = 1'b1;
    hold(1);
    chk({2'h0, state_o}, 8'h01, "reset state");
    chk({main_bias_en_o, enable_button_filt_n_o, rail_en_o}, 8'h10, "reset outputs");
    deb_gp(1'b1);
    deb_gp(1'b0);
    general_input_pin_i = 1'b1;
    hold(DEB + 6);
    gpi_as_input_i = 1'b0;
    hold(DEB + 6);
    chk({7'h0, general_input_filt_o}, 8'h00, "output pin filtered");
    enable_button_input_n_i = 1'b0;
    hold(DEB - 2);
    enable_button_input_n_i = 1'b1;
    hold(DEB + 6);
    chk(8'(state_o), 8'(pss_pkg::PSS_ST_OFF), "button glitch");
    chk({7'h0, enable_button_filt_n_o}, 8'h01, "button filtered");
    sw_on_req_i = 1'b1;
    follow('{4'h8, 4'h9, 4'hB, 4'hF}, '{0, 0, SLOT, 2 * SLOT});
    wait_st(pss_pkg::PSS_ST_ON);
    sw_on_req_i = 1'b0;
    follow('{4'hB, 4'h9, 4'h8, 4'h0}, '{0, 2 * SLOT, SLOT, 0});
    wait_st(pss_pkg::PSS_ST_OFF);
    charge_source_input_i = 1'b1;
    wait_st(pss_pkg::PSS_ST_ON);
    chk({6'h0, main_bias_en_o, charge_source_filt_o}, 8'h03, "charge on");
    temp_below_release_i = 1'b0;
    temp_above_lockout_i = 1'b1;
    hold(4);
    chk({overtemp_lockout_o, rail_en_o}, 8'h10, "lockout cuts rails");
    hold(30);
    temp_above_lockout_i = 1'b0;
    hold(10);
    chk(8'(state_o), 8'(pss_pkg::PSS_ST_OFF), "restart blocked");
    temp_below_release_i = 1'b1;
    wait_st(pss_pkg::PSS_ST_ON);
    charge_source_input_i = 1'b0;
    wait_st(pss_pkg::PSS_ST_OFF);
    irq_step(1'b1, 1'b0, 1);
    irq_step(1'b1, 1'b1, 0);
    irq_step(1'b0, 1'b1, 1);
    irq_step(1'b0, 1'b0, 0);
    temp_irq_mask_i = 2'h1;
    irq_step(1'b0, 1'b1, 1);
    irq_step(1'b1, 1'b1, 0);
    irq_step(1'b1, 1'b0, 1);
    finish_test();
  end
endmodule : test_pss_top
